// ==== rtl/seq_pkg.sv ====
// Shared constants, types and helpers for the programmable logic sequencer.
package seq_pkg;
    localparam int N_IN = 16;
    localparam int N_ST = 6;
    localparam int N_OUT = 8;
    localparam int N_REG = 14;
    localparam int N_TERMS = 48;
    localparam int N_VARS = 22;
    localparam int AND_W = 46;
    localparam int CFG_WORDS = 192;
    localparam int SYNC_W = 28;
    localparam logic [9:0] CFG_END_ADDR = 10'h300;
    localparam logic [9:0] CTRL_ADDR = 10'h300;
    localparam logic [9:0] STATUS_ADDR = 10'h304;
    localparam logic [31:0] WORD0_MASK = 32'hffffffff;
    localparam logic [31:0] WORD1_MASK = 32'h00003fff;
    localparam logic [31:0] WORD2_MASK = 32'hbfff3fff;
    localparam logic [31:0] WORD3_MASK = 32'h00000000;
    localparam int OR_C_BIT = 31;
    localparam int OR_K_LSB = 16;
    localparam logic [1:0] LINK_DEAD = 2'h0;
    localparam logic [1:0] LINK_TRUE = 2'h1;
    localparam logic [1:0] LINK_FALSE = 2'h2;
    localparam logic [1:0] LINK_ANY = 2'h3;
    localparam logic [5:0] STATE_RESET = 6'h3f;
    localparam logic [7:0] OUT_RESET = 8'hff;
    localparam logic OPT_PRESET_RESET = 1'b1;

    typedef struct packed {
        logic comp;
        logic [13:0] k;
        logic [13:0] j;
    } or_links_t;

    typedef enum {BUS_IDLE, BUS_ACK} bus_state_t;

    // A dead link pair is the erased code, so a blank term never fires.
    function automatic logic lit_match(input logic [1:0] code, input logic v);
        case (code)
            LINK_TRUE: return v;
            LINK_FALSE: return !v;
            LINK_ANY: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
endpackage

// ==== rtl/product_term.sv ====
// One AND-array product term with its complement-array literal.
`timescale 1ns/100ps
module product_term (
    input wire logic [seq_pkg::N_VARS-1:0] vars_in,
    input wire logic [seq_pkg::AND_W-1:0] and_cfg_in,
    input wire logic comp_in,
    output logic base_out,
    output logic term_out
);
    import seq_pkg::*;

    logic [N_VARS:0] hit;

    genvar v;
    generate
        for (v = 0; v < N_VARS; v++) begin : g_var
            assign hit[v] = lit_match(and_cfg_in[2*v+1:2*v], vars_in[v]);
        end
    endgenerate

    assign hit[N_VARS] = lit_match(and_cfg_in[AND_W-1:AND_W-2], comp_in);
    // The base excludes the complement literal, which breaks the feedback loop.
    assign base_out = &hit[N_VARS-1:0];
    assign term_out = base_out & hit[N_VARS];
endmodule

// ==== rtl/logic_sequencer.sv ====
// Programmable Mealy sequencer with Avalon-MM access to its link arrays.
//
// Summary of operation
// - Every term can test all sixteen inputs and six state bits, true or inverted.
// - Any set of terms may drive any state or output register bit.
// - Next state and outputs come from present state and present inputs.
// - Each tested variable is required true, required false, or ignored.
// - Complement signal is low when any connected term is active, else high.
// - All register bits are rising-edge J-K flops; set with reset toggles.
// - After power-up every state and output register bit is one.
// - A term with both links of one variable intact never fires.
// - Blank configuration has all links inactive and preset option selected.
// - J and K used alone behave exactly as set and reset.
// - Diagnostic modes load registers directly and expose the state register.
// - Observe input shows state bits on pins 0 to 5; outputs unchanged.
// - Load inputs clock state from pins 0-5 or outputs from pins 0-7.
// - Preset option forces all ones and stops clocking; else low enables pins.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module logic_sequencer (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [9:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic [seq_pkg::N_IN-1:0] EXTERNAL_INPUTS_IN,
    input wire logic ASYNC_SET_OR_DRIVE_ENABLE_PIN_IN,
    input wire logic STATE_OBSERVE_DIAG_INPUT_IN,
    input wire logic STATE_LOAD_DIAG_INPUT_IN,
    input wire logic OUTPUT_LOAD_DIAG_INPUT_IN,
    input wire logic [seq_pkg::N_OUT-1:0] OUTPUT_PINS_IN,
    output logic [seq_pkg::N_OUT-1:0] OUTPUT_PINS_OUT,
    output logic [seq_pkg::N_OUT-1:0] OUTPUT_PINS_OE_OUT
);
    import seq_pkg::*;

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [N_IN-1:0] ext_s;
    logic [N_OUT-1:0] pins_s;
    logic pe_s;
    logic obs_s;
    logic sload_s;
    logic oload_s;

    logic [31:0] cfg_q [CFG_WORDS];
    logic opt_preset_q;
    bus_state_t bus_q;
    logic waitreq_q;
    logic [31:0] readdata_q;
    logic req;
    logic [7:0] word_idx;
    logic cfg_hit;
    logic [31:0] be_mask;
    logic [31:0] rd_d;

    logic [N_ST-1:0] state_q;
    logic [N_ST-1:0] state_d;
    logic [N_OUT-1:0] out_q;
    logic [N_OUT-1:0] out_d;
    logic [N_OUT-1:0] pins_q;
    logic [N_OUT-1:0] pins_d;
    logic [N_OUT-1:0] oe_q;
    logic [N_OUT-1:0] oe_d;

    logic [N_VARS-1:0] vars;
    logic [N_TERMS-1:0] term_base;
    logic [N_TERMS-1:0] term_full;
    logic [N_TERMS-1:0] c_conn;
    or_links_t lnk [N_TERMS];
    logic comp;
    logic [N_REG-1:0] j_any;
    logic [N_REG-1:0] k_any;
    logic [N_REG-1:0] cur;
    logic [N_REG-1:0] reg_jk;
    logic pre;
    logic run;

    // Pins are asynchronous to the clock, so all pass a two-stage synchroniser.
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {OUTPUT_PINS_IN, OUTPUT_LOAD_DIAG_INPUT_IN, STATE_LOAD_DIAG_INPUT_IN,
                        STATE_OBSERVE_DIAG_INPUT_IN, ASYNC_SET_OR_DRIVE_ENABLE_PIN_IN, EXTERNAL_INPUTS_IN};
            sync2_q <= sync1_q;
        end
    end

    assign ext_s = sync2_q[N_IN-1:0];
    assign pe_s = sync2_q[N_IN];
    assign obs_s = sync2_q[N_IN+1];
    assign sload_s = sync2_q[N_IN+2];
    assign oload_s = sync2_q[N_IN+3];
    assign pins_s = sync2_q[SYNC_W-1:SYNC_W-N_OUT];

    // Bus slave: one wait cycle, then the access completes.
    assign req = AVS_READ_IN | AVS_WRITE_IN;
    assign word_idx = AVS_ADDRESS_IN[9:2];
    assign cfg_hit = AVS_ADDRESS_IN < CFG_END_ADDR;
    assign be_mask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                      {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};

    function automatic logic [31:0] word_mask(input logic [1:0] w);
        case (w)
            2'h0: return WORD0_MASK;
            2'h1: return WORD1_MASK;
            2'h2: return WORD2_MASK;
            default: return WORD3_MASK;
        endcase
    endfunction

    always_comb begin
        rd_d = 32'h00000000;
        if (cfg_hit) begin
            rd_d = cfg_q[word_idx];
        end else if (AVS_ADDRESS_IN == CTRL_ADDR) begin
            rd_d = {31'h0, opt_preset_q};
        end else if (AVS_ADDRESS_IN == STATUS_ADDR) begin
            rd_d = {17'h0, comp, out_q, state_q};
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            bus_q <= BUS_IDLE;
            waitreq_q <= 1'b1;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    if (req) begin
                        bus_q <= BUS_ACK;
                        waitreq_q <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    bus_q <= BUS_IDLE;
                    waitreq_q <= 1'b1;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                    waitreq_q <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            readdata_q <= 32'h00000000;
        end else if (bus_q == BUS_IDLE && AVS_READ_IN) begin
            readdata_q <= rd_d;
        end
    end

    // Blank arrays are all-dead links and the preset option is chosen.
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg_q[i] <= 32'h00000000;
            end
            opt_preset_q <= OPT_PRESET_RESET;
        end else if (bus_q == BUS_ACK && AVS_WRITE_IN) begin
            if (cfg_hit) begin
                cfg_q[word_idx] <= ((cfg_q[word_idx] & ~be_mask) | (AVS_WRITEDATA_IN & be_mask))
                                   & word_mask(word_idx[1:0]);
            end else if (AVS_ADDRESS_IN == CTRL_ADDR && AVS_BYTEENABLE_IN[0]) begin
                opt_preset_q <= AVS_WRITEDATA_IN[0];
            end
        end
    end

    // Terms see the present inputs and the fed-back state bits.
    assign vars = {state_q, ext_s};

    genvar t;
    generate
        for (t = 0; t < N_TERMS; t++) begin : g_term
            assign lnk[t] = '{comp: cfg_q[4*t+2][OR_C_BIT],
                              k: cfg_q[4*t+2][OR_K_LSB+N_REG-1:OR_K_LSB],
                              j: cfg_q[4*t+2][N_REG-1:0]};
            assign c_conn[t] = lnk[t].comp;
            product_term u_term (
                .vars_in(vars),
                .and_cfg_in({cfg_q[4*t+1][AND_W-33:0], cfg_q[4*t]}),
                .comp_in(comp),
                .base_out(term_base[t]),
                .term_out(term_full[t])
            );
        end
    endgenerate

    // Terms feeding the complement array ignore its own literal to avoid oscillation.
    assign comp = ~|(term_base & c_conn);

    always_comb begin
        j_any = '0;
        k_any = '0;
        for (int i = 0; i < N_TERMS; i++) begin
            if (term_full[i]) begin
                j_any = j_any | lnk[i].j;
                k_any = k_any | lnk[i].k;
            end
        end
    end

    assign cur = {out_q, state_q};

    genvar b;
    generate
        for (b = 0; b < N_REG; b++) begin : g_jk
            assign reg_jk[b] = (j_any[b] & k_any[b]) ? ~cur[b] :
                               j_any[b] ? 1'b1 :
                               k_any[b] ? 1'b0 :
                               cur[b];
        end
    endgenerate

    // The preset pin is sampled, so it acts one clock after the two-stage synchroniser delay.
    assign pre = opt_preset_q & pe_s;
    assign run = !pre && !oload_s && !sload_s && !obs_s;

    always_comb begin
        state_d = state_q;
        out_d = out_q;
        if (pre) begin
            state_d = STATE_RESET;
            out_d = OUT_RESET;
        end else if (oload_s) begin
            out_d = pins_s;
        end else if (sload_s) begin
            state_d = pins_s[N_ST-1:0];
        end else if (!obs_s) begin
            {out_d, state_d} = reg_jk;
        end
    end

    always_comb begin
        pins_d = out_d;
        if (!pre && obs_s) begin
            pins_d = {out_d[N_OUT-1:N_ST], state_d};
        end
        // Buffers release while the pins act as load inputs, but preset keeps them driven high.
        if ((oload_s || sload_s) && !pre) begin
            oe_d = '0;
        end else begin
            oe_d = {N_OUT{opt_preset_q | !pe_s}};
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            state_q <= STATE_RESET;
            out_q <= OUT_RESET;
        end else begin
            state_q <= state_d;
            out_q <= out_d;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            pins_q <= OUT_RESET;
            oe_q <= {N_OUT{1'b1}};
        end else begin
            pins_q <= pins_d;
            oe_q <= oe_d;
        end
    end

    assign OUTPUT_PINS_OUT = pins_q;
    assign OUTPUT_PINS_OE_OUT = oe_q;
    assign AVS_READDATA_OUT = readdata_q;
    assign AVS_WAITREQUEST_OUT = waitreq_q;

    chk_reset_ones: assert property (@(posedge MCLK_IN)
        $fell(SYS_RST_IN) |-> state_q == 6'h3f && out_q == 8'hff && opt_preset_q)
        else $error("Registers or option not preset after reset.");

    chk_dead_link: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        cfg_q[0][1:0] == 2'h0 |-> !term_full[0] && !term_base[0])
        else $error("Term with both links intact became active.");

    chk_comp_nor: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        comp == !(|(term_base & c_conn)))
        else $error("Complement signal disagrees with connected terms.");

    chk_jk_toggle: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        run |=> ((cur ^ $past(cur)) & $past(j_any & k_any)) == $past(j_any & k_any))
        else $error("Register bit did not toggle with set and reset.");

    chk_set_reset: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        run && (j_any[6] ^ k_any[6]) |=> out_q[0] == $past(j_any[6]) && pins_q[0] == out_q[0])
        else $error("Output bit 0 not set or reset as commanded.");

    chk_hold_idle: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        run && j_any == '0 && k_any == '0 |=> $stable(state_q) && $stable(out_q))
        else $error("Register changed with no set or reset active.");

    chk_observe_pins: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !pre && obs_s && !oload_s && !sload_s |=> pins_q[5:0] == state_q && $stable(out_q))
        else $error("Observe mode did not show state on pins.");

    chk_state_load: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !pre && sload_s && !oload_s |=> state_q == $past(pins_s[5:0]) && $stable(out_q) && oe_q == '0)
        else $error("State load from pins failed.");

    chk_preset_hold: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        pre |=> state_q == 6'h3f && out_q == 8'hff && pins_q == 8'hff && oe_q == 8'hff)
        else $error("Preset did not force all ones.");

    chk_oe_release: assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
        !opt_preset_q && pe_s |=> oe_q == '0)
        else $error("Pins driven while output enable is deasserted.");
endmodule

// ==== bench/board_pin_model.sv ====
// Board-side model that shares the eight output pins with the sequencer.
`timescale 1ns/100ps
module board_pin_model (
    input wire logic clk_in,
    input wire logic [7:0] dut_out_in,
    input wire logic [7:0] dut_oe_in,
    input wire logic drive_en_in,
    input wire logic [7:0] drive_val_in,
    output logic [7:0] level_out
);
    logic [7:0] last_q = 8'h00;
    // A pin that nobody drives floats, so it shows the inverse of its last level, never a stale value.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (dut_oe_in[i]) begin
                level_out[i] = dut_out_in[i];
            end else if (drive_en_in) begin
                level_out[i] = drive_val_in[i];
            end else begin
                level_out[i] = ~last_q[i];
            end
        end
    end
    always_ff @(posedge clk_in) begin
        last_q <= level_out;
    end
endmodule

// ==== bench/test_logic_sequencer.sv ====
// Self-checking bench for the programmable logic sequencer.
`timescale 1ns/100ps
module test_logic_sequencer;
    import seq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] addr = 10'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] be = 4'hf;
    logic [31:0] rdata, got;
    logic waitreq;
    logic [N_IN-1:0] ext = 16'h0000;
    logic opt_pin = 1'b0;
    logic observe = 1'b0;
    logic st_load = 1'b0;
    logic out_load = 1'b0;
    logic drive_en = 1'b0;
    logic [7:0] drive_val = 8'h00;
    logic [7:0] pins_lvl, pins_out, pins_oe;
    int num_errors = 0;
    int samples_checked = 0;

    // A 100 ns period leaves ample room for input set-up plus clock-to-output delay.
    initial begin
        forever #50 clk = ~clk;
    end

    logic_sequencer u_dut (
        .MCLK_IN(clk),
        .SYS_RST_IN(rst),
        .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(be),
        .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitreq),
        .EXTERNAL_INPUTS_IN(ext),
        .ASYNC_SET_OR_DRIVE_ENABLE_PIN_IN(opt_pin),
        .STATE_OBSERVE_DIAG_INPUT_IN(observe),
        .STATE_LOAD_DIAG_INPUT_IN(st_load),
        .OUTPUT_LOAD_DIAG_INPUT_IN(out_load),
        .OUTPUT_PINS_IN(pins_lvl),
        .OUTPUT_PINS_OUT(pins_out),
        .OUTPUT_PINS_OE_OUT(pins_oe)
    );

    board_pin_model u_board (
        .clk_in(clk),
        .dut_out_in(pins_out),
        .dut_oe_in(pins_oe),
        .drive_en_in(drive_en),
        .drive_val_in(drive_val),
        .level_out(pins_lvl)
    );

    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // The strobe is released and one edge passes, so the next access never re-raises it in the same step.
    task automatic bus(input logic is_wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= is_wr;
        rd <= !is_wr;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr_w(input logic [9:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000, 4'hf);
        check(got, e);
    endtask

    task automatic st_chk(input logic [31:0] e);
        rd_chk(STATUS_ADDR, e);
    endtask

    task automatic prog(input int t, input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
        wr_w(10'(16 * t), w0);
        wr_w(10'(16 * t + 4), w1);
        wr_w(10'(16 * t + 8), w2);
    endtask

    task automatic diag_load(input logic to_out, input logic [7:0] v);
        drive_val <= v;
        drive_en <= 1'b1;
        out_load <= to_out;
        st_load <= !to_out;
        settle(6);
        check({24'h000000, pins_oe}, 32'h00000000);
        out_load <= 1'b0;
        st_load <= 1'b0;
        settle(5);
        drive_en <= 1'b0;
        settle(5);
    endtask

    initial begin
        settle(20000);
        num_errors++;
        summarize();
    end

    // Unused terms keep dead links on inputs 0-15, so no idle term loads the OR array.
    initial begin
        settle(10);
        rst <= 1'b0;
        settle(1);
        check({24'h000000, pins_out}, 32'h000000ff);
        check({24'h000000, pins_oe}, 32'h000000ff);
        rd_chk(10'h000, 32'h00000000);
        rd_chk(CTRL_ADDR, 32'h00000001);
        st_chk(32'h00007fff);
        wr_w(10'h00c, 32'hffffffff);
        rd_chk(10'h00c, 32'h00000000);
        rd_chk(10'h308, 32'h00000000);
        bus(1'b1, 10'h028, 32'hffffffff, 4'h1);
        rd_chk(10'h028, 32'h000000ff);
        wr_w(10'h074, 32'hffffffff);
        rd_chk(10'h074, 32'h00003fff);
        wr_w(CTRL_ADDR, 32'h00000000);
        prog(0, 32'hfffffffd, 32'h00003fff, 32'h00010000);
        prog(5, 32'hfffffdff, 32'h00003ffe, 32'h01000000);
        ext <= 16'h0010;
        settle(5);
        st_chk(32'h00007fff);
        ext <= 16'h0011;
        settle(5);
        st_chk(32'h00007efe);
        ext <= 16'h0000;
        settle(5);
        st_chk(32'h00007efe);
        prog(2, 32'hffffffcf, 32'h00003fff, 32'h00020000);
        ext <= 16'h0004;
        settle(5);
        st_chk(32'h00007efe);
        prog(1, 32'hfffffff7, 32'h00003fff, 32'h00400040);
        ext <= 16'h0002;
        settle(1);
        ext <= 16'h0000;
        settle(5);
        st_chk(32'h00007ebe);
        check({24'h000000, pins_out}, 32'h000000fa);
        prog(6, 32'hfffff7ff, 32'h00003fff, 32'h00000040);
        ext <= 16'h0020;
        settle(5);
        ext <= 16'h0000;
        settle(5);
        st_chk(32'h00007efe);
        prog(3, 32'hffffff7f, 32'h00003fff, 32'h80000000);
        ext <= 16'h0008;
        settle(5);
        st_chk(32'h00003efe);
        prog(4, 32'hffffffff, 32'h00001fff, 32'h00800000);
        settle(5);
        st_chk(32'h00003efe);
        ext <= 16'h0000;
        settle(5);
        st_chk(32'h00007e7e);
        observe <= 1'b1;
        settle(5);
        check({24'h000000, pins_out}, 32'h000000fe);
        st_chk(32'h00007e7e);
        observe <= 1'b0;
        settle(5);
        diag_load(1'b0, 8'h2a);
        st_chk(32'h00007e6a);
        diag_load(1'b1, 8'h5c);
        st_chk(32'h0000572a);
        check({24'h000000, pins_out}, 32'h0000005c);
        opt_pin <= 1'b1;
        settle(5);
        check({24'h000000, pins_oe}, 32'h00000000);
        opt_pin <= 1'b0;
        settle(5);
        check({24'h000000, pins_oe}, 32'h000000ff);
        wr_w(CTRL_ADDR, 32'h00000001);
        ext <= 16'h0001;
        opt_pin <= 1'b1;
        settle(5);
        st_chk(32'h00007fff);
        st_chk(32'h00007fff);
        check({24'h000000, pins_out}, 32'h000000ff);
        opt_pin <= 1'b0;
        ext <= 16'h0000;
        summarize();
    end
endmodule
